/* File: hdl/mcs_sync_core.sv */
// Multichip sync logic: clock generation phase, back-end lock, FIFO align.
// Assumes all inputs synchronous to core_clk, the converter sample clock.
//
// Behaviour
// - Synced parts share clock generation state and read aligned FIFO data
// - Keep fixed relation between phase counter, FIFO output and sync edge
// - Data rate mode syncs per data word; FIFO rate per eight words
// - Data rate mode resets FIFO read point on every realign, no elasticity
// - Clock multiplier in use forces data rate mode
// - Sub-cycle alignment needs only the reference sync clock; align strobe resets the FIFO pointers
// - Soft FIFO align by register write aligns within two data clocks
// - With clock multiplier, reference input doubles as sync signal
// - Status bit 6 reads high once phase is constant to sync signal
// - Status bit 7 flags lost sync, sticky through relock until control is rewritten
// - Lock only after (11+avg)x64 to (11+avg)x128 stable sample cycles
`timescale 1ns/100ps
`default_nettype none
module mcs_sync_core #(
	parameter int DATA_W   = 16,
	parameter int DATA_DIV = 2
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              nrst,
	// Register port
	input  wire logic              reg_wr,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	output var  logic [7:0]        reg_rdata_q,
	// Clocking mode
	input  wire logic              pll_mode,
	// Link from the data source
	input  wire logic              reference_sync_clock_in,
	input  wire logic              input_data_clock,
	input  wire logic              fifo_align_strobe,
	input  wire logic [DATA_W-1:0] data_in,
	// Sample stream to the converter core
	output var  logic [DATA_W-1:0] sample_q,
	output var  logic              sample_valid_q,
	input  wire logic              sample_ready,
	// Status
	output var  logic              sync_locked_q
);

	localparam int SW = (DATA_DIV > 2) ? $clog2(DATA_DIV) : 1;
	localparam logic [SW-1:0] SUB_LAST = SW'(DATA_DIV - 1);
	localparam int AW = mcs_pkg::FIFO_AW;

	// All checks run on the sample clock, quiet during reset
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	// Lock threshold in sample cycles for an averaging setting
	function automatic logic [mcs_pkg::LOCK_CNT_W-1:0] lock_target(
		input logic [2:0] avg,
		input int         mult
	);
		lock_target = mcs_pkg::LOCK_CNT_W'((mcs_pkg::LOCK_BASE + int'(avg))
			* mult);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Sync state group

	mcs_pkg::mcs_state_t           state_q, state_d;
	logic [7:0]                    ctrl_q, ctrl_d;
	logic [SW-1:0]                 sub_q, sub_d;
	logic [2:0]                    word_q, word_d;
	logic [mcs_pkg::LOCK_CNT_W-1:0] lock_cnt_q, lock_cnt_d;
	logic                          lost_q, lost_d;
	logic                          ref_prev_q;
	logic                          soft_aln, realign, eff_drate;
	logic                          ref_edge, at_zero, enable, ctrl_wr;
	logic [2:0]                    avg;

	// Next values of control, phase counters and lock tracking
	always_comb begin
		ctrl_wr  = reg_wr && (reg_addr == mcs_pkg::SYNC_CONTROL_ADDR);
		ctrl_d   = ctrl_q;
		soft_aln = 1'b0;
		lost_d   = lost_q;
		if (ctrl_wr) begin
			ctrl_d = reg_wdata;
			ctrl_d[mcs_pkg::CTRL_SOFTALN_BIT] = 1'b0; // Self clearing
			soft_aln = reg_wdata[mcs_pkg::CTRL_SOFTALN_BIT];
			lost_d = 1'b0; // Cleared by rewriting control
		end
		enable = ctrl_q[mcs_pkg::CTRL_ENABLE_BIT];
		avg    = ctrl_q[mcs_pkg::CTRL_AVG_LSB +: mcs_pkg::CTRL_AVG_W];
		eff_drate = ctrl_q[mcs_pkg::CTRL_DATARATE_BIT] | pll_mode;
		// one reference input is the sync
		ref_edge = reference_sync_clock_in & ~ref_prev_q;
		at_zero = (sub_q == '0) && (eff_drate || word_q == 3'h0);
		// Free running clock generation phase
		if (sub_q == SUB_LAST) begin
			sub_d  = '0;
			word_d = word_q + 3'h1;
		end else begin
			sub_d  = sub_q + SW'(1);
			word_d = word_q;
		end
		realign    = 1'b0;
		state_d    = state_q;
		lock_cnt_d = lock_cnt_q;
		case (state_q)
			mcs_pkg::MCS_IDLE: begin
				lock_cnt_d = '0;
				if (enable) begin
					state_d = mcs_pkg::MCS_ALIGN;
				end
			end
			mcs_pkg::MCS_ALIGN: begin
				if (!enable) begin
					state_d = mcs_pkg::MCS_IDLE;
				end else if (ref_edge && !at_zero) begin
					realign    = 1'b1;
					lock_cnt_d = '0;
				end else if (lock_cnt_q >= lock_target(avg,
						mcs_pkg::LOCK_MIN_MULT)) begin
					state_d = mcs_pkg::MCS_LOCKED;
				end else begin
					lock_cnt_d = lock_cnt_q + 1'b1;
				end
			end
			mcs_pkg::MCS_LOCKED: begin
				if (!enable) begin
					state_d = mcs_pkg::MCS_IDLE;
				end else if (ref_edge && !at_zero) begin
					lost_d = 1'b1;
					if (ctrl_q[mcs_pkg::CTRL_PERIODIC_BIT]) begin
						realign    = 1'b1;
						lock_cnt_d = '0;
						state_d    = mcs_pkg::MCS_ALIGN;
					end else begin
						state_d = mcs_pkg::MCS_LOST;
					end
				end
			end
			mcs_pkg::MCS_LOST: begin
				if (!enable) begin
					state_d = mcs_pkg::MCS_IDLE;
				end
			end
			default: begin
				state_d = mcs_pkg::MCS_IDLE;
			end
		endcase
		if (realign) begin
			sub_d  = SW'(1);
			word_d = 3'h0;
		end
	end

	// Registers of the sync group
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_q       <= mcs_pkg::MCS_IDLE;
			ctrl_q        <= mcs_pkg::SYNC_CONTROL_RST;
			sub_q         <= '0;
			word_q        <= 3'h0;
			lock_cnt_q    <= '0;
			lost_q        <= 1'b0;
			ref_prev_q    <= 1'b0;
			sync_locked_q <= 1'b0;
		end else begin
			state_q       <= state_d;
			ctrl_q        <= ctrl_d;
			sub_q         <= sub_d;
			word_q        <= word_d;
			lock_cnt_q    <= lock_cnt_d;
			lost_q        <= lost_d;
			ref_prev_q    <= reference_sync_clock_in;
			sync_locked_q <= (state_d == mcs_pkg::MCS_LOCKED);
		end
	end

	////////////////////////////////////////////////////////////////////
	// FIFO and output buffer group

	logic [AW-1:0]     wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	logic [1:0]        frame_cnt_q, frame_cnt_d, cnt_q, cnt_d, c;
	logic [DATA_W-1:0] buf1_q, buf1_d, sample_d, ram_q;
	logic              dci_prev_q, pend_q, valid_d;
	logic              dci_edge, frame_fire, fifo_rst, rd_en, rd_ok, pop;
	logic [7:0]        rdata_d;

	// Write on data clock edge, read once per data period
	always_comb begin
		dci_edge = input_data_clock & ~dci_prev_q;
		frame_cnt_d = frame_cnt_q;
		if (!fifo_align_strobe) begin
			frame_cnt_d = 2'h0;
		end else if (dci_edge && frame_cnt_q != mcs_pkg::FRAME_WORDS) begin
			frame_cnt_d = frame_cnt_q + 2'h1;
		end
		frame_fire = fifo_align_strobe && dci_edge
			&& (frame_cnt_q == mcs_pkg::FRAME_WORDS - 2'h1);
		// strobe and sync edge both align
		fifo_rst = frame_fire | soft_aln | realign;
		// Stall on full buffer trades a late word for no loss
		rd_ok = (cnt_q == 2'h0) || (cnt_q == 2'h1 && !pend_q);
		rd_en = (sub_q == '0) && rd_ok && !fifo_rst;
		if (fifo_rst) begin
			wr_ptr_d = mcs_pkg::WR_PTR_RST;
			rd_ptr_d = mcs_pkg::RD_PTR_RST;
		end else begin
			wr_ptr_d = wr_ptr_q + AW'(dci_edge);
			rd_ptr_d = rd_ptr_q + AW'(rd_en);
		end
		// Two entry buffer: pop first, then push the RAM word
		pop      = sample_valid_q & sample_ready;
		sample_d = sample_q;
		buf1_d   = buf1_q;
		c        = cnt_q;
		if (pop) begin
			sample_d = buf1_q;
			c        = c - 2'h1;
		end
		if (pend_q) begin
			if (c == 2'h0) begin
				sample_d = ram_q;
			end else begin
				buf1_d = ram_q;
			end
			c = c + 2'h1;
		end
		cnt_d   = c;
		valid_d = (c != 2'h0);
		rdata_d = 8'h00;
		if (reg_addr == mcs_pkg::SYNC_CONTROL_ADDR) begin
			rdata_d = ctrl_q;
		end else if (reg_addr == mcs_pkg::SYNC_STATUS_ADDR) begin
			rdata_d[mcs_pkg::STAT_LOST_BIT]   = lost_q;
			rdata_d[mcs_pkg::STAT_LOCKED_BIT] = sync_locked_q;
			rdata_d[2:0] = word_q;
		end
	end

	// Registers of the data group
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			wr_ptr_q       <= mcs_pkg::WR_PTR_RST;
			rd_ptr_q       <= mcs_pkg::RD_PTR_RST;
			frame_cnt_q    <= 2'h0;
			dci_prev_q     <= 1'b0;
			pend_q         <= 1'b0;
			cnt_q          <= 2'h0;
			buf1_q         <= '0;
			sample_q       <= '0;
			sample_valid_q <= 1'b0;
			reg_rdata_q    <= 8'h00;
		end else begin
			wr_ptr_q       <= wr_ptr_d;
			rd_ptr_q       <= rd_ptr_d;
			frame_cnt_q    <= frame_cnt_d;
			dci_prev_q     <= input_data_clock;
			pend_q         <= rd_en;
			cnt_q          <= cnt_d;
			buf1_q         <= buf1_d;
			sample_q       <= sample_d;
			sample_valid_q <= valid_d;
			reg_rdata_q    <= rdata_d;
		end
	end

	// Elastic FIFO storage
	mcs_fifo_ram #(
		.W     (DATA_W),
		.DEPTH (mcs_pkg::FIFO_DEPTH),
		.AW    (AW)
	) u_ram (
		.core_clk  (core_clk),
		.nrst      (nrst),
		.wr_en     (dci_edge),
		.wr_addr   (wr_ptr_q),
		.wr_data   (data_in),
		.rd_en     (rd_en),
		.rd_addr   (rd_ptr_q),
		.rd_data_q (ram_q)
	);

	////////////////////////////////////////////////////////////////////
	// Checks

	a_lock_min_time: assert property (
		$rose(sync_locked_q) |-> $past(lock_cnt_q)
			>= lock_target(avg, mcs_pkg::LOCK_MIN_MULT))
		else $error("locked before minimum stable time");
	a_lock_max_time: assert property (
		lock_cnt_q <= lock_target(avg, mcs_pkg::LOCK_MAX_MULT))
		else $error("lock timer ran past maximum");
	a_slip_drops_lock: assert property (
		(state_q == mcs_pkg::MCS_LOCKED && enable && ref_edge && !at_zero)
		|=> !sync_locked_q ##0 lost_q)
		else $error("phase slip kept lock or missed lost flag");
	a_pll_data_rate: assert property (
		(pll_mode && sub_q == '0) |-> at_zero)
		else $error("multiplier mode left FIFO rate selected");
	a_frame_reset: assert property (
		frame_fire |=> (rd_ptr_q == mcs_pkg::RD_PTR_RST)
			&& (wr_ptr_q == mcs_pkg::WR_PTR_RST))
		else $error("align strobe did not reset pointers");
	a_soft_align: assert property (
		(ctrl_wr && reg_wdata[mcs_pkg::CTRL_SOFTALN_BIT])
		|=> rd_ptr_q == mcs_pkg::RD_PTR_RST)
		else $error("soft align did not reset read pointer");
	a_realign_phase: assert property (
		realign |=> sub_q == SW'(1)
			##1 !(ref_edge && !at_zero && sub_q == '0))
		else $error("realign did not land phase");
	a_data_period: assert property (
		(sub_q == SUB_LAST && !realign) |=> sub_q == '0
			&& word_q == $past(word_q) + 3'h1)
		else $error("phase counter period wrong");
	a_buf_bound: assert property (
		cnt_q != 2'h3 && (sample_valid_q == (cnt_q != 2'h0)))
		else $error("output buffer count broken");

endmodule
`default_nettype wire

/* File: hdl/mcs_pkg.sv */
// Constants, register map and state types of the multichip sync block.
// Assumes nothing of its surroundings; compiled before all design files.
package mcs_pkg;

	// Register map on the register port
	localparam logic [7:0] SYNC_CONTROL_ADDR = 8'h10;
	localparam logic [7:0] SYNC_STATUS_ADDR  = 8'h12;
	localparam logic [7:0] SYNC_CONTROL_RST  = 8'h00;

	// Field positions in sync_control
	localparam int CTRL_ENABLE_BIT   = 7;
	localparam int CTRL_DATARATE_BIT = 6;
	localparam int CTRL_SOFTALN_BIT  = 5;
	localparam int CTRL_PERIODIC_BIT = 3;
	localparam int CTRL_AVG_LSB      = 0;
	localparam int CTRL_AVG_W        = 3;

	// Field positions in sync_status
	localparam int STAT_LOST_BIT   = 7;
	localparam int STAT_LOCKED_BIT = 6;

	// Lock timing: (LOCK_BASE + averaging) x multiplier sample cycles
	localparam int LOCK_BASE     = 11;
	localparam int LOCK_MIN_MULT = 64;
	localparam int LOCK_MAX_MULT = 128;
	localparam int LOCK_CNT_W    = 12;

	// Elastic FIFO geometry and reset offset
	localparam int         FIFO_DEPTH  = 8;
	localparam int         FIFO_AW     = 3;
	localparam logic [2:0] WR_PTR_RST  = 3'h0;
	localparam logic [2:0] RD_PTR_RST  = 3'h4;
	localparam logic [1:0] FRAME_WORDS = 2'h2;

	// Sync state machine, Gray coded along idle-align-locked-lost
	typedef enum logic [1:0] {
		MCS_IDLE   = 2'b00,
		MCS_ALIGN  = 2'b01,
		MCS_LOCKED = 2'b11,
		MCS_LOST   = 2'b10
	} mcs_state_t;

endpackage

/* File: hdl/mcs_fifo_ram.sv */
// Storage of the elastic input FIFO with one write and one read port.
// Assumes one clock; read data appear one edge after rd_en.
`timescale 1ns/100ps
`default_nettype none
module mcs_fifo_ram #(
	parameter int W     = 16,
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	// Clock and reset
	input  wire logic          core_clk,
	input  wire logic          nrst,
	// Write port
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [W-1:0]  wr_data,
	// Read port
	input  wire logic          rd_en,
	input  wire logic [AW-1:0] rd_addr,
	output var  logic [W-1:0]  rd_data_q
);

	logic [W-1:0] mem [DEPTH];

	// Array has no reset; only read data are cleared
	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Registered read
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rd_data_q <= '0;
		end else if (rd_en) begin
			rd_data_q <= mem[rd_addr];
		end
	end

endmodule
`default_nettype wire

/* File: sim/mcs_src_model.sv */
// Data source model: sync clock, data clock, align strobe and data words.
// Assumes the bench steers period, slip and strobe requests on core_clk.
`timescale 1ns/100ps
`default_nettype none
module mcs_src_model (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       nrst,
	// Bench controls
	input  wire logic [4:0] ref_period,
	input  wire logic       ref_slip,
	input  wire logic       frame_req,
	// Link to the device
	output logic            ref_clk,
	output logic            data_clk,
	output logic            frame,
	output logic [15:0]     data
);
	logic [4:0]  ref_cnt_q = 5'h00;
	logic        dclk_q = 1'b0;
	logic [15:0] word_q = 16'h0000;
	logic [2:0]  frm_q = 3'h0;
	logic [4:0]  ref_nxt;

	////////////////////////////////////////
	assign ref_nxt = ref_cnt_q + 5'h01;
	always @(posedge core_clk) begin
		if (!nrst) begin
			ref_cnt_q <= 5'h00;
			dclk_q <= 1'b0;
			word_q <= 16'h0000;
			frm_q <= 3'h0;
		end else begin
			// Slip holds the phase one cycle
			if (!ref_slip) begin
				ref_cnt_q <= (ref_nxt >= ref_period) ? 5'h00 : ref_nxt;
			end
			dclk_q <= !dclk_q;
			if (!dclk_q) begin
				word_q <= word_q + 16'h0001;
			end
			frm_q <= frame_req ? 3'h4 : frm_q - {2'h0, frm_q != 3'h0};
		end
	end
	assign ref_clk = ref_cnt_q < (ref_period >> 1);
	assign data_clk = dclk_q;
	assign frame = frm_q != 3'h0;
	// Word held only while the data clock is high
	assign data = dclk_q ? word_q : ~word_q;
endmodule
`default_nettype wire

/* File: sim/tb_multichip_dac_sync_logic.sv */
// Self-checking bench of the sync core against a data source model.
// Assumes mcs_pkg and the design files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_multichip_dac_sync_logic;
	localparam int LMIN = mcs_pkg::LOCK_BASE * mcs_pkg::LOCK_MIN_MULT;
	localparam int LMAX = mcs_pkg::LOCK_BASE * mcs_pkg::LOCK_MAX_MULT;
	logic        core_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        reg_wr = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        pll_mode = 1'b0;
	logic        sample_ready = 1'b1;
	logic [4:0]  ref_period = 5'h02;
	logic        ref_slip = 1'b0;
	logic        frame_req = 1'b0;
	logic [7:0]  reg_rdata_q;
	logic [15:0] sample_q;
	logic        sample_valid_q;
	logic        sync_locked_q;
	logic        ref_clk;
	logic        data_clk;
	logic        frame;
	logic [15:0] data;
	logic [7:0]  v;
	int          failures = 0;
	int          cmp_count = 0;

	// 100 MHz sample clock
	always #5 core_clk = !core_clk;

	mcs_src_model u_mcs_src_model (.core_clk(core_clk), .nrst(nrst),
		.ref_period(ref_period), .ref_slip(ref_slip),
		.frame_req(frame_req), .ref_clk(ref_clk), .data_clk(data_clk),
		.frame(frame), .data(data));

	mcs_sync_core #(.DATA_W(16), .DATA_DIV(2)) u_mcs_sync_core (
		.core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata_q(reg_rdata_q), .pll_mode(pll_mode),
		.reference_sync_clock_in(ref_clk), .input_data_clock(data_clk),
		.fifo_align_strobe(frame), .data_in(data), .sample_q(sample_q),
		.sample_valid_q(sample_valid_q), .sample_ready(sample_ready),
		.sync_locked_q(sync_locked_q));

	////////////////////////////////////////
	// Compare and count
	task automatic check(input string w, input logic [15:0] s, e);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", w, e, s);
		end
	endtask

	// Register write, one strobe cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// Read lands one edge after the address
	task automatic rchk(input string w, input logic [7:0] a, m, e);
		@(posedge core_clk);
		reg_addr <= a;
		@(posedge core_clk);
		#1;
		v = reg_rdata_q;
		check(w, {8'h00, v & m}, {8'h00, e});
	endtask

	// Bounded wait for lock, optional lower bound
	task automatic lock_check(input logic lo);
		int n;
		n = 0;
		#1;
		while (sync_locked_q !== 1'b1 && n < 1500) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (lo) begin
			check("lock_min", {15'h0000, n + 2 >= LMIN}, 16'h0001);
		end
		check("lock_max", {15'h0000, n <= LMAX + 12}, 16'h0001);
	endtask

	// Shift the sync edge by one cycle
	task automatic slip();
		@(posedge core_clk);
		ref_slip <= 1'b1;
		@(posedge core_clk);
		ref_slip <= 1'b0;
		repeat (6) @(posedge core_clk);
		#1;
	endtask

	// Take words with a short stall; early words may be stale
	task automatic stream();
		logic [15:0] prev;
		logic [15:0] held;
		logic        hv;
		int          k;
		int          g;
		k = 0;
		g = 0;
		hv = 1'b0;
		prev = 16'h0000;
		while (k < 24 && g < 300) begin
			@(posedge core_clk);
			sample_ready <= !(g >= 30 && g < 34);
			g++;
			#1;
			if (hv) check("sample_hold", sample_q, held);
			hv = sample_valid_q === 1'b1 && sample_ready !== 1'b1;
			held = sample_q;
			if (sample_valid_q === 1'b1 && sample_ready === 1'b1) begin
				if (k > 10) check("seq", sample_q, prev + 16'h0001);
				prev = sample_q;
				k++;
			end
		end
		check("words", 16'(k), 16'h0018);
	endtask

	////////////////////////////////////////
	task automatic t_reset();
		check("lock_rst", {15'h0000, sync_locked_q}, 16'h0000);
		rchk("ctrl_rst", 8'h10, 8'hFF, mcs_pkg::SYNC_CONTROL_RST);
		wr(8'h12, 8'hFF);
		rchk("status_ro", 8'h12, 8'hC0, 8'h00);
		rchk("unmapped", 8'h20, 8'hFF, 8'h00);
		$display("test reset done");
	endtask

	task automatic t_datarate();
		wr(8'h10, 8'hC8);
		lock_check(1'b1);
		rchk("ctrl", 8'h10, 8'hFF, 8'hC8);
		rchk("status", 8'h12, 8'hC0, 8'h40);
		$display("test data rate done");
	endtask

	task automatic t_align();
		@(posedge core_clk);
		frame_req <= 1'b1;
		@(posedge core_clk);
		frame_req <= 1'b0;
		stream();
		wr(8'h10, 8'hE8);
		rchk("soft_clr", 8'h10, 8'hFF, 8'hC8);
		stream();
		$display("test align done");
	endtask

	task automatic t_slip();
		slip();
		check("realign", {15'h0000, sync_locked_q}, 16'h0000);
		rchk("lost_sticky", 8'h12, 8'h80, 8'h80);
		lock_check(1'b0);
		$display("test slip done");
	endtask

	task automatic t_lost();
		wr(8'h10, 8'hC0);
		lock_check(1'b0);
		slip();
		check("lost_drop", {15'h0000, sync_locked_q}, 16'h0000);
		rchk("lost_set", 8'h12, 8'hC0, 8'h80);
		wr(8'h10, 8'h00);
		rchk("lost_clr", 8'h12, 8'hC0, 8'h00);
		$display("test lost done");
	endtask

	task automatic t_modes();
		@(posedge core_clk);
		ref_period <= 5'h10;
		wr(8'h10, 8'h88);
		lock_check(1'b1);
		rchk("fifo_ctrl", 8'h10, 8'hFF, 8'h88);
		wr(8'h10, 8'h00);
		@(posedge core_clk);
		pll_mode <= 1'b1;
		ref_period <= 5'h02;
		wr(8'h10, 8'h88);
		lock_check(1'b1);
		check("pll_lock", {15'h0000, sync_locked_q}, 16'h0001);
		$display("test modes done");
	endtask

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Watchdog well past the expected run
	initial begin
		#200000;
		failures++;
		finish_test();
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		t_reset();
		t_datarate();
		t_align();
		t_slip();
		t_lost();
		t_modes();
		finish_test();
	end
endmodule
`default_nettype wire
